// file: design/dgc_config.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// [R1] Chain-four skip fetches every fourth doubleword
// [R2] Test-mode rise resets FIFO and line pointers
// [R3] Line replicate repeats previous line on odd
// [R4] Software loads half lines, normal timing
// [R5] Whole-frame dirty marks frame on writes
// [R6] Otherwise mark line chosen by write Y
// [R7] Insert one static frame between updates
// [R8] Static frame: failed lines fetch uncompressed
// [R9] Urgent request ends at stop level times four
// [R10] Urgent request starts at begin level times four
// [R11] Software keeps stop above begin, both nonzero
// [R12] Multiplier: low, half, pass, double
// [R13] Dot and pixel halving follow multiplier
// [R14] Decompressor runs only while enabled
// [R15] Compressor runs only while enabled
// [R16] Panning compat forces 16-byte alignment at split
// [R17] Otherwise alignment kept across split
// [R18] Video clock is core half or quarter
// [R19] Divide choice valid only with port on
// [R20] Video port enable turns port on
// [R21] Dot halve bit halves dot clock
module dgc_config #(
  parameter int AW = 24, // Fetch doubleword address width
  parameter int LW = 12, // Line number width
  parameter int FW = 7 // FIFO level width
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Frame and line timing
  input wire logic frame_start,
  input wire logic line_advance,
  // Display fetch
  input wire logic fetch_advance,
  output logic [AW-1:0] fetch_dword_addr,
  output logic [LW-1:0] source_line,
  // Buffer pointer control
  output logic fifo_ptr_reset,
  output logic cline_rptr_reset,
  output logic fifo_test_mode_access_en,
  // Frame buffer writes and dirty flags
  input wire logic fb_write,
  input wire logic [LW-1:0] fb_write_y,
  output logic mark_all_dirty,
  output logic mark_line_dirty,
  output logic [LW-1:0] mark_line_y,
  // Compression
  input wire logic line_compress_failed,
  output logic update_frame,
  output logic fetch_uncompressed,
  output logic compress_run,
  output logic decompress_run,
  // Display FIFO and memory request
  input wire logic [FW-1:0] fifo_level,
  output logic urgent_fill_req,
  // Dot clock
  input wire logic dot_clock_in,
  output logic dot_tick,
  output logic pixel_tick,
  // Panning
  input wire logic pan_load,
  input wire logic [3:0] pan_value,
  input wire logic split_cross,
  output logic [3:0] pan_align,
  // Video port
  output logic video_port_on,
  output logic video_clock_out
);
  import dgc_pkg::*;

  // Level field plus unit shift must fit the FIFO level
  if (FW < 4 + DGC_LVL_SHIFT || AW < 3 || LW < 2) begin : g_bad_params
    $error("dgc_config: parameter out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cfg; // Configuration register
    logic [31:0] rdata; // Read data, one cycle after strobe
    logic [AW-1:0] fetch_addr; // Doubleword fetch address
    logic [LW-1:0] line_cnt; // Displayed line number
    logic [LW-1:0] src_line; // Frame buffer line fetched
    logic test_q; // Previous test-mode bit
    logic ptr_rst; // Pointer reset pulse
    logic mark_all; // Whole-frame dirty pulse
    logic mark_line; // Single-line dirty pulse
    logic [LW-1:0] mark_y; // Line to mark
    dgc_frame_t frm; // Update or static frame
    logic urgent; // Urgent fill request
    logic [3:0] pan; // Pixel alignment
    logic vcnt; // Quarter-rate phase
    logic vclk; // Video clock level
    logic dot_clock_in_q; // Previous synchronised dot clock
  } dgc_state_t;

  dgc_state_t st;
  dgc_state_t next_st;

  // Field views
  logic [FW-1:0] stop_lvl; // Stop level in entries
  logic [FW-1:0] begin_lvl; // Begin level in entries
  dgc_mul_t mul_sel; // Multiplier selection
  logic dot_clock_in_s; // Synchronised dot clock pin
  logic dot_clock_in_rise; // Dot clock rising edge
  logic dot_clock_in_fall; // Dot clock falling edge
  logic half_tick; // Every second rising edge
  logic mul_tick; // Multiplier output pulse
  logic [LW-1:0] next_line; // Line counter after advance

  assign stop_lvl = FW'({st.cfg[DGC_F_STOP_LSB+:4], 2'b00});
  assign begin_lvl = FW'({st.cfg[DGC_F_BEGIN_LSB+:4], 2'b00});
  assign mul_sel = dgc_mul_t'(st.cfg[DGC_F_MUL_LSB+:2]);

  // ----------------------------------------------------------------
  // Dot clock path
  // ----------------------------------------------------------------
  // Pin passes two flops before edge detection
  dgc_sync2 u_dot_clock_in_sync (
    .clk(clk), .nrst(nrst), .pin(dot_clock_in), .level(dot_clock_in_s)
  );
  assign dot_clock_in_rise = dot_clock_in_s & ~st.dot_clock_in_q;
  assign dot_clock_in_fall = ~dot_clock_in_s & st.dot_clock_in_q;
  // Half rate: every second rising edge
  dgc_div2 u_mul_half (
    .clk(clk), .nrst(nrst), .halve(1'b1), .tick_in(dot_clock_in_rise), .tick_out(half_tick)
  );
  // Multiplier selection [R12]
  always_comb begin
    case (mul_sel)
      DGC_MUL_LOW: mul_tick = 1'b0;
      DGC_MUL_HALF: mul_tick = half_tick;
      DGC_MUL_PASS: mul_tick = dot_clock_in_rise;
      default: mul_tick = dot_clock_in_rise | dot_clock_in_fall;
    endcase
  end

  // Dividers sit after the multiplier [R13] [R21]
  dgc_div2 u_dot_halve (
    .clk(clk), .nrst(nrst), .halve(st.cfg[DGC_B_DOT_HALVE]), .tick_in(mul_tick),
    .tick_out(dot_tick)
  );
  // Pixel clock derived from the dot clock [R13]
  dgc_div2 u_pix_halve (
    .clk(clk), .nrst(nrst), .halve(st.cfg[DGC_B_PIX_HALVE]), .tick_in(dot_tick),
    .tick_out(pixel_tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.dot_clock_in_q = dot_clock_in_s;
    // Register write and read
    if (reg_wr && reg_addr == DGC_CFG_ADDR) begin
      next_st.cfg = reg_wdata & DGC_CFG_MASK;
    end
    if (!reg_rd) begin
      next_st.rdata = '0;
    end else if (reg_addr == DGC_CFG_ADDR) begin
      next_st.rdata = st.cfg;
    end else if (reg_addr == DGC_STAT_ADDR) begin
      next_st.rdata = {28'h0000000, st.vclk, st.frm, st.urgent, st.test_q};
    end else begin
      next_st.rdata = '0;
    end
    // Fetch address: stride one or four [R1]
    if (frame_start) begin
      next_st.fetch_addr = '0;
    end else if (fetch_advance) begin
      if (st.cfg[DGC_B_CHAIN4]) begin
        next_st.fetch_addr = st.fetch_addr + AW'(DGC_STRIDE_CHAIN4);
      end else begin
        next_st.fetch_addr = st.fetch_addr + AW'(DGC_STRIDE_LINEAR);
      end
    end
    // Line count and replicated source line [R3]
    next_line = frame_start ? '0 : (line_advance ? st.line_cnt + LW'(1) : st.line_cnt);
    next_st.line_cnt = next_line;
    if (st.cfg[DGC_B_LINE_REP]) begin
      next_st.src_line = next_line >> 1;
    end else begin
      next_st.src_line = next_line;
    end
    // Pointer reset on test-mode rise [R2]
    next_st.test_q = st.cfg[DGC_B_TEST];
    next_st.ptr_rst = st.cfg[DGC_B_TEST] & ~st.test_q;
    // Dirty marking [R5] [R6]
    next_st.mark_all = fb_write & st.cfg[DGC_B_FRM_DIRTY];
    next_st.mark_line = fb_write & ~st.cfg[DGC_B_FRM_DIRTY];
    if (fb_write) begin
      next_st.mark_y = fb_write_y;
    end
    // Frame type sequencing [R7]
    if (frame_start) begin
      case (st.frm)
        DGC_FRM_UPDATE: begin
          if (st.cfg[DGC_B_STATIC_INS]) begin
            next_st.frm = DGC_FRM_STATIC;
          end
        end
        default: next_st.frm = DGC_FRM_UPDATE;
      endcase
    end
    // Urgent fill: start wins if both met [R10] [R9]
    if (fifo_level <= begin_lvl) begin
      next_st.urgent = 1'b1;
    end else if (fifo_level >= stop_lvl) begin
      next_st.urgent = 1'b0;
    end
    // Pixel alignment across split boundary [R16] [R17]
    if (split_cross) begin
      if (st.cfg[DGC_B_PAN]) begin
        next_st.pan = 4'h0;
      end
    end else if (pan_load) begin
      next_st.pan = pan_value;
    end
    // Video clock: half or quarter core rate [R18] [R19] [R20]
    if (!st.cfg[DGC_B_VID_EN]) begin
      next_st.vcnt = 1'b0;
      next_st.vclk = 1'b0;
    end else if (st.cfg[DGC_B_VCLK_DIV]) begin
      next_st.vcnt = ~st.vcnt;
      if (st.vcnt) begin
        next_st.vclk = ~st.vclk;
      end
    end else begin
      next_st.vcnt = 1'b0;
      next_st.vclk = ~st.vclk;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.cfg <= DGC_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign fetch_dword_addr = st.fetch_addr;
  assign source_line = st.src_line;
  assign fifo_ptr_reset = st.ptr_rst;
  assign cline_rptr_reset = st.ptr_rst;
  assign fifo_test_mode_access_en = st.test_q;
  assign mark_all_dirty = st.mark_all;
  assign mark_line_dirty = st.mark_line;
  assign mark_line_y = st.mark_y;
  assign update_frame = (st.frm == DGC_FRM_UPDATE);
  // Failed or disabled lines come from the raw frame buffer [R8]
  assign fetch_uncompressed = line_compress_failed | ~decompress_run;
  // Compression engines gated by their enables [R14] [R15]
  assign decompress_run = st.cfg[DGC_B_DECOMP];
  assign compress_run = st.cfg[DGC_B_COMP] & update_frame;
  assign urgent_fill_req = st.urgent;
  assign pan_align = st.pan;
  assign video_port_on = st.cfg[DGC_B_VID_EN];
  assign video_clock_out = st.vclk;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_test_rise;
    st.cfg[DGC_B_TEST] && !st.test_q;
  endsequence
  sequence s_reset_pulse;
    fifo_ptr_reset && cline_rptr_reset ##1 !fifo_ptr_reset;
  endsequence
  property p_ptr_reset;
    @(posedge clk) disable iff (!nrst) s_test_rise |=> s_reset_pulse;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("pointer reset missing"); // [R2]
  property p_chain4;
    @(posedge clk) disable iff (!nrst)
      fetch_advance && !frame_start && st.cfg[DGC_B_CHAIN4]
      |=> fetch_dword_addr == $past(fetch_dword_addr) + AW'(DGC_STRIDE_CHAIN4);
  endproperty
  a_chain4: assert property (p_chain4) else $error("chain four stride wrong"); // [R1]
  property p_frame_dirty;
    @(posedge clk) disable iff (!nrst)
      fb_write && st.cfg[DGC_B_FRM_DIRTY] |=> mark_all_dirty && !mark_line_dirty;
  endproperty
  a_frame_dirty: assert property (p_frame_dirty) else $error("frame dirty wrong"); // [R5]
  property p_line_dirty;
    @(posedge clk) disable iff (!nrst)
      fb_write && !st.cfg[DGC_B_FRM_DIRTY] |=> mark_line_dirty && mark_line_y == $past(fb_write_y);
  endproperty
  a_line_dirty: assert property (p_line_dirty) else $error("line dirty wrong"); // [R6]
  property p_static_insert;
    @(posedge clk) disable iff (!nrst)
      frame_start && update_frame && st.cfg[DGC_B_STATIC_INS] |=> !update_frame;
  endproperty
  a_static_insert: assert property (p_static_insert) else $error("no static frame"); // [R7]
  property p_urgent_start;
    @(posedge clk) disable iff (!nrst) fifo_level <= begin_lvl |=> urgent_fill_req;
  endproperty
  a_urgent_start: assert property (p_urgent_start) else $error("urgent not raised"); // [R10]
  property p_urgent_stop;
    @(posedge clk) disable iff (!nrst)
      fifo_level >= stop_lvl && fifo_level > begin_lvl |=> !urgent_fill_req;
  endproperty
  a_urgent_stop: assert property (p_urgent_stop) else $error("urgent not ended"); // [R9]
  property p_pan;
    @(posedge clk) disable iff (!nrst) split_cross && st.cfg[DGC_B_PAN] |=> pan_align == 4'h0;
  endproperty
  a_pan: assert property (p_pan) else $error("alignment not forced"); // [R16]
  property p_vclk_quarter;
    @(posedge clk) disable iff (!nrst)
      (st.cfg[DGC_B_VID_EN] && st.cfg[DGC_B_VCLK_DIV]) [*4]
      |-> video_clock_out != $past(video_clock_out, 2);
  endproperty
  a_vclk_quarter: assert property (p_vclk_quarter) else $error("video clock not quarter"); // [R18]
  property p_vclk_off;
    @(posedge clk) disable iff (!nrst) !video_port_on [*2] |-> !video_clock_out;
  endproperty
  a_vclk_off: assert property (p_vclk_off) else $error("video clock while off"); // [R19]
  // A write that clears the enable stops the compressor on the next cycle
  property p_comp_gate;
    @(posedge clk) disable iff (!nrst)
      reg_wr && reg_addr == DGC_CFG_ADDR && !reg_wdata[DGC_B_COMP] |=> !compress_run;
  endproperty
  a_comp_gate: assert property (p_comp_gate) else $error("compressor ran disabled"); // [R15]
endmodule // dgc_config

// file: design/dgc_div2.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Pulse halver: passes every second enable pulse
// ----------------------------------------------------------------
module dgc_div2 (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bypass when low, halve when high
  input wire logic halve,
  input wire logic tick_in,
  output logic tick_out
);
  import dgc_pkg::*;

  typedef struct packed {
    logic phase; // Toggles on each input pulse while halving
  } dgc_div_t;

  dgc_div_t st;
  dgc_div_t next_st;

  // Phase advances only on input pulses while halving
  always_comb begin
    next_st = st;
    if (!halve) begin
      next_st.phase = 1'b0;
    end else if (tick_in) begin
      next_st.phase = ~st.phase;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Output pulse is combinational: the input pulse, gated by phase while halving
  assign tick_out = halve ? (tick_in & st.phase) : tick_in;
endmodule // dgc_div2

// file: design/dgc_sync2.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two flip-flop synchroniser for a pin level
// ----------------------------------------------------------------
module dgc_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Asynchronous level in, synchronised level out
  input wire logic pin,
  output logic level
);
  import dgc_pkg::*;

  typedef struct packed {
    logic meta; // First stage, read only by the second
    logic sync; // Second stage
  } dgc_sync_t;

  dgc_sync_t st;
  dgc_sync_t next_st;

  // Shift the pin through both stages
  always_comb begin
    next_st.meta = pin;
    next_st.sync = st.meta;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.sync;
endmodule // dgc_sync2

// file: inc/dgc_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the display general configuration block
// ----------------------------------------------------------------
package dgc_pkg;
  // Register byte addresses
  localparam logic [7:0] DGC_CFG_ADDR = 8'h00;
  localparam logic [7:0] DGC_STAT_ADDR = 8'h04;
  // Reset value of the configuration register
  localparam logic [31:0] DGC_CFG_RESET = 32'h0000_0000;
  // Writable bits of the configuration register
  localparam logic [31:0] DGC_CFG_MASK = 32'hD705_FFFC;
  // Field positions in the configuration register
  localparam int DGC_B_DOT_HALVE = 31;
  localparam int DGC_B_PIX_HALVE = 30;
  localparam int DGC_B_VID_EN = 28;
  localparam int DGC_B_CHAIN4 = 26;
  localparam int DGC_B_TEST = 25;
  localparam int DGC_B_LINE_REP = 24;
  localparam int DGC_B_FRM_DIRTY = 18;
  localparam int DGC_B_STATIC_INS = 16;
  localparam int DGC_F_STOP_LSB = 12;
  localparam int DGC_F_BEGIN_LSB = 8;
  localparam int DGC_F_MUL_LSB = 6;
  localparam int DGC_B_DECOMP = 5;
  localparam int DGC_B_COMP = 4;
  localparam int DGC_B_PAN = 3;
  localparam int DGC_B_VCLK_DIV = 2;
  // Fetch strides in doublewords
  localparam int DGC_STRIDE_LINEAR = 1;
  localparam int DGC_STRIDE_CHAIN4 = 4;
  // Fill threshold unit: four 64-bit entries, as a shift
  localparam int DGC_LVL_SHIFT = 2;
  // Core clock and video clock divide figures
  localparam int DGC_CORE_HZ = 50_000_000;
  localparam int DGC_VCLK_DIV_LO = 2;
  localparam int DGC_VCLK_DIV_HI = 4;
  // Core cycles between video clock toggles
  localparam int DGC_VCLK_HOLD_HI = DGC_VCLK_DIV_HI / 2;
  // Dot clock multiplier encodings
  typedef enum logic [1:0] {
    DGC_MUL_LOW = 2'h0,
    DGC_MUL_HALF = 2'h1,
    DGC_MUL_PASS = 2'h2,
    DGC_MUL_DOUBLE = 2'h3
  } dgc_mul_t;
  // Update or static frame
  typedef enum logic {
    DGC_FRM_UPDATE = 1'h0,
    DGC_FRM_STATIC = 1'h1
  } dgc_frame_t;
endpackage

// file: tb/tb_display_general_config.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Self-checking bench for the general configuration block
// ----------------------------------------------------------------
module tb_display_general_config;
  import dgc_pkg::*;
  // Row: config word, read-back, dot and pixel ticks, video clock toggles
  typedef struct {
    logic [31:0] wd;
    logic [31:0] rb;
    int dot;
    int pix;
    int vck;
  } dgc_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0] stb = 6'h00; // Strobe group: frame, line, fetch, write, load, split
  logic [23:0] fetch_dword_addr;
  logic [11:0] source_line, fb_write_y = 12'h000, mark_line_y;
  logic fifo_ptr_reset, cline_rptr_reset, fifo_test_mode_access_en;
  logic mark_all_dirty, mark_line_dirty, line_compress_failed = 1'b0;
  logic update_frame, fetch_uncompressed, compress_run, decompress_run;
  logic [6:0] fifo_level = 7'h00;
  logic urgent_fill_req, dot_clock_in = 1'b0, dot_tick, pixel_tick;
  logic [3:0] pan_value = 4'h0, pan_align;
  logic video_port_on, video_clock_out, vck_last = 1'b0;
  int n_errors = 0, checks = 0, cyc = 0, n_dot = 0, n_pix = 0, n_vck = 0, n_tm = 0;
  int d0, p0, v0;
  logic [31:0] rdv;
  dgc_row_t rows[11];
  int lv[6] = '{20, 8, 15, 16, 9, 8};
  logic ex[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  dgc_config i_dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_start(stb[0]), .line_advance(stb[1]), .fetch_advance(stb[2]),
    .fetch_dword_addr(fetch_dword_addr), .source_line(source_line),
    .fifo_ptr_reset(fifo_ptr_reset), .cline_rptr_reset(cline_rptr_reset),
    .fifo_test_mode_access_en(fifo_test_mode_access_en), .fb_write(stb[3]), .fb_write_y(fb_write_y),
    .mark_all_dirty(mark_all_dirty), .mark_line_dirty(mark_line_dirty),
    .mark_line_y(mark_line_y), .line_compress_failed(line_compress_failed),
    .update_frame(update_frame), .fetch_uncompressed(fetch_uncompressed),
    .compress_run(compress_run), .decompress_run(decompress_run),
    .fifo_level(fifo_level), .urgent_fill_req(urgent_fill_req),
    .dot_clock_in(dot_clock_in), .dot_tick(dot_tick), .pixel_tick(pixel_tick),
    .pan_load(stb[4]), .pan_value(pan_value), .split_cross(stb[5]),
    .pan_align(pan_align), .video_port_on(video_port_on),
    .video_clock_out(video_clock_out)
  );
  // ----------------------------------------------------------------
  // Clock, pin clock, monitors and timeout
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  // Dot pin: period of eight core cycles
  always begin
    repeat (4) @(posedge clk);
    dot_clock_in <= ~dot_clock_in;
  end
  // Counts ticks, video clock toggles and pointer reset pulses
  always @(posedge clk) begin
    if (dot_tick === 1'b1) n_dot++;
    if (pixel_tick === 1'b1) n_pix++;
    if (video_clock_out !== vck_last) n_vck++;
    vck_last = video_clock_out;
    if (fifo_ptr_reset === 1'b1 && cline_rptr_reset === 1'b1) n_tm++;
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      $display("unexpected at %0t: run too long", $time);
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // One-cycle strobe; outputs sampled after the edge that follows
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    stb <= m;
    @(posedge clk);
    stb <= 6'h00;
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{
      '{32'h0000_0080, 32'h0000_0080, 16, 16, 0}, '{32'h0000_00C0, 32'h0000_00C0, 32, 32, 0},
      '{32'h0000_0040, 32'h0000_0040, 8, 8, 0}, '{32'h0000_0000, 32'h0000_0000, 0, 0, 0},
      '{32'h8000_0080, 32'h8000_0080, 8, 8, 0}, '{32'h4000_0080, 32'h4000_0080, 16, 8, 0},
      '{32'hC000_00C0, 32'hC000_00C0, 16, 8, 0}, '{32'h1000_0080, 32'h1000_0080, 16, 16, 128},
      '{32'h1000_0084, 32'h1000_0084, 16, 16, 64}, '{32'h0000_0084, 32'h0000_0084, 16, 16, 0},
      '{32'hFDFF_FFFF, 32'hD505_FFFC, 16, 8, 64}};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // Reset state
    check(update_frame, 1'b1, "update after reset");
    check(fetch_uncompressed, 1'b1, "uncompressed after reset");
    check(video_clock_out, 1'b0, "video clock after reset");
    rd(DGC_CFG_ADDR, rdv);
    check(rdv, DGC_CFG_RESET, "config reset value");
    $display("test reset done");
    // Table rows: read-back, dot and pixel rates, video clock
    foreach (rows[i]) begin
      wr(DGC_CFG_ADDR, rows[i].wd);
      rd(DGC_CFG_ADDR, rdv);
      check(rdv, rows[i].rb, "read-back");
      check(video_port_on, rows[i].wd[28], "port enable");
      repeat (8) @(posedge clk);
      #1;
      d0 = n_dot;
      p0 = n_pix;
      v0 = n_vck;
      repeat (128) @(posedge clk);
      #1;
      check(n_dot - d0, rows[i].dot, "dot ticks");
      check(n_pix - p0, rows[i].pix, "pixel ticks");
      check(n_vck - v0, rows[i].vck, "video toggles");
    end
    $display("test rows done");
    // Unmapped address: write ignored, read zero
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, rdv);
    check(rdv, 32'h0, "unmapped read");
    rd(DGC_CFG_ADDR, rdv);
    check(rdv, 32'hD505_FFFC, "config after unmapped write");
    $display("test unmapped done");
    // Fetch stride and line replicate, both settings
    for (int k = 0; k < 2; k++) begin
      wr(DGC_CFG_ADDR, k ? 32'h0500_0000 : 32'h0);
      pulse(6'h01);
      repeat (3) pulse(6'h06);
      check(fetch_dword_addr, k ? 24'hC : 24'h3, "fetch address");
      check(source_line, k ? 12'h1 : 12'h3, "source line");
    end
    $display("test fetch done");
    // Dirty marking by line and whole frame
    fb_write_y <= 12'h005;
    pulse(6'h08);
    check({mark_all_dirty, mark_line_dirty}, 2'b01, "line dirty");
    check(mark_line_y, 12'h005, "dirty line y");
    wr(DGC_CFG_ADDR, 32'h0004_0000);
    pulse(6'h08);
    check({mark_all_dirty, mark_line_dirty}, 2'b10, "frame dirty");
    $display("test dirty done");
    // Static frame insertion and compression gating
    wr(DGC_CFG_ADDR, 32'h0001_0030);
    for (int k = 0; k < 3; k++) begin
      pulse(6'h01);
      check(update_frame, k[0], "frame type");
      check(compress_run, k[0], "compress gate");
      check(decompress_run, 1'b1, "decompress on");
      check(fetch_uncompressed, 1'b0, "compressed fetch");
    end
    @(posedge clk);
    line_compress_failed <= 1'b1;
    #1;
    check(fetch_uncompressed, 1'b1, "failed line fetch");
    rd(DGC_STAT_ADDR, rdv);
    check(rdv[2], 1'b1, "static status");
    line_compress_failed <= 1'b0;
    $display("test static done");
    // Urgent fill thresholds: begin 2 (8 entries), stop 4 (16 entries)
    wr(DGC_CFG_ADDR, 32'h0000_4200);
    foreach (lv[i]) begin
      fifo_level <= 7'(lv[i]);
      repeat (3) @(posedge clk);
      #1;
      check(urgent_fill_req, ex[i], "urgent request");
      rd(DGC_STAT_ADDR, rdv);
      check(rdv[1], ex[i], "urgent status");
    end
    $display("test urgent done");
    // Test mode: rise pulses once, a held bit gives none
    d0 = n_tm;
    wr(DGC_CFG_ADDR, 32'h0200_0000);
    wr(DGC_CFG_ADDR, 32'h0200_0008);
    repeat (4) @(posedge clk);
    #1;
    check(n_tm - d0, 1, "pointer reset pulses");
    check(fifo_test_mode_access_en, 1'b1, "test access");
    wr(DGC_CFG_ADDR, 32'h0);
    wr(DGC_CFG_ADDR, 32'h0200_0000);
    repeat (4) @(posedge clk);
    #1;
    check(n_tm - d0, 2, "second rise");
    $display("test mode done");
    // Panning across a split, with and without compat
    wr(DGC_CFG_ADDR, 32'h0);
    pan_value <= 4'h5;
    pulse(6'h10);
    pulse(6'h20);
    check(pan_align, 4'h5, "alignment kept");
    wr(DGC_CFG_ADDR, 32'h0000_0008);
    pan_value <= 4'h9;
    pulse(6'h30);
    check(pan_align, 4'h0, "alignment forced");
    $display("test panning done");
    // Mid-run reset with the video port running
    wr(DGC_CFG_ADDR, 32'h1000_0018);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(video_clock_out, 1'b0, "video clock after mid reset");
    check(video_port_on, 1'b0, "port after mid reset");
    rd(DGC_CFG_ADDR, rdv);
    check(rdv, DGC_CFG_RESET, "config after mid reset");
    $display("test mid reset done");
    test_done();
  end
endmodule // tb_display_general_config
